// ===== hw/hbd_pkg.sv
// package for the dual h-bridge brushed dc motor control block
// assumes one 50 mhz clock that doubles as the chopping oscillator
package hbd_pkg;

   // clock and timing
   localparam int          CLK_PERIOD_NS     = 20;   // aclk period
   localparam int          ANA_BLANK_NS      = 400;  // fixed analog blanking
   // least time, rounded up to whole cycles
   localparam int          ANA_BLANK_CYC_I   = (ANA_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0]  ANA_BLANK_CYC     = ANA_BLANK_CYC_I[4:0];
   localparam logic [2:0]  DIG_BLANK_SHORT   = 3'h4;  // select low: 4 osc clocks
   localparam logic [2:0]  DIG_BLANK_LONG    = 3'h6;  // select high: 6 osc clocks
   localparam logic [3:0]  CHOP_FAST_AT      = 4'ha;  // 11th clock edge of cycle
   localparam logic [3:0]  CHOP_LAST         = 4'hf;  // 16th clock ends cycle

   // register map, byte addresses
   localparam logic [3:0]  REG_CTRL_OFS      = 4'h0;
   localparam logic [3:0]  REG_STATUS_OFS    = 4'h4;
   localparam int          CTRL_CHOP_EN_BIT  = 0;
   localparam logic        CTRL_CHOP_EN_RST  = 1'b1;
   localparam int          ST_MODE_A_LSB     = 0;   // 3 bits
   localparam int          ST_MODE_B_LSB     = 3;   // 3 bits
   localparam int          ST_PHASE_A_LSB    = 6;   // 2 bits
   localparam int          ST_PHASE_B_LSB    = 8;   // 2 bits
   localparam int          ST_BLANK_A_BIT    = 10;
   localparam int          ST_BLANK_B_BIT    = 11;
   localparam int          ST_PARALLEL_BIT   = 12;
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   // per channel bridge state
   typedef enum logic [2:0] {
      MODE_STANDBY,
      MODE_STOP,
      MODE_CW,
      MODE_CCW,
      MODE_BRAKE
   } hbd_mode_t;

   // chopping phase
   typedef enum logic [1:0] {
      PH_CHARGE,
      PH_SLOW,
      PH_FAST
   } hbd_phase_t;

   // one channel's logic inputs
   typedef struct packed {
      logic dir_first;
      logic dir_second;
      logic drive_brake;
   } hbd_chan_in_t;

   // one output pin: level and active-low enable
   typedef struct packed {
      logic drv;
      logic oe_n;
   } hbd_pin_t;

endpackage : hbd_pkg

// ===== hw/hbd_decode.sv
// truth-table decode of one channel's direction and drive/brake inputs
// assumes inputs already registered by the caller; purely combinational
module hbd_decode
   import hbd_pkg::*;
(
   input  hbd_chan_in_t in_c,        // channel inputs
   input  wire logic    all_low,     // every live input of the device low
   output hbd_mode_t    mode         // decoded bridge state
);

   // decode per channel; standby needs the whole device idle
   always_comb begin
      mode = MODE_STOP;
      if (all_low) begin
         mode = MODE_STANDBY;
      end else if (in_c.dir_first && in_c.dir_second) begin
         mode = MODE_BRAKE;
      end else if (!in_c.drive_brake && (in_c.dir_first || in_c.dir_second)) begin
         mode = MODE_BRAKE;
      end else if (in_c.dir_first) begin
         mode = MODE_CW;
      end else if (in_c.dir_second) begin
         mode = MODE_CCW;
      end else begin
         mode = MODE_STOP;
      end
   end

endmodule : hbd_decode

// ===== hw/hbd_chop.sv
// chopping counter, decay phase and blanking timers of one channel
// assumes the sense input is the current comparator, synchronous to aclk
module hbd_chop
   import hbd_pkg::*;
(
   input  wire logic  aclk,          // oscillator clock
   input  wire logic  aresetn,       // sync reset, active low
   input  wire logic  chop_en,       // constant-current chopping on
   input  wire logic  driving,       // channel in cw or ccw
   input  wire logic  blank_long,    // blanking length select
   input  wire logic  dir_change,    // any direction input toggled
   input  wire logic  sense,         // current threshold reached
   output hbd_phase_t phase,         // current decay phase
   output logic       blank_active   // comparator masked
);

   logic [3:0] cnt_q;                // oscillator counter
   logic [2:0] dblk_q;               // digital blanking remaining
   logic [4:0] ablk_q;               // analog blanking remaining
   hbd_phase_t phase_q;              // phase register
   logic       new_cycle;            // counter wraps this edge
   logic       blank_start;          // open a fresh window

   assign new_cycle   = (cnt_q == CHOP_LAST);
   assign blank_start = new_cycle || dir_change;
   assign blank_active = (dblk_q != 3'h0) || (ablk_q != 5'h0);
   assign phase       = phase_q;

   // free-running 16 clock chopping counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // digital window length picked by the select pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dblk_q <= 3'h0;
      end else if (blank_start) begin
         dblk_q <= blank_long ? DIG_BLANK_LONG : DIG_BLANK_SHORT;
      end else if (dblk_q != 3'h0) begin
         dblk_q <= dblk_q - 3'h1;
      end
   end

   // fixed analog window, not configurable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ablk_q <= 5'h0;
      end else if (blank_start) begin
         ablk_q <= ANA_BLANK_CYC;
      end else if (ablk_q != 5'h0) begin
         ablk_q <= ablk_q - 5'h1;
      end
   end

   // charge until threshold, slow decay, fast decay from the 11th clock
   // direct pwm drive simply keeps the phase at charge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_q <= PH_CHARGE;
      end else if (!chop_en || !driving) begin
         phase_q <= PH_CHARGE;
      end else if (new_cycle) begin
         phase_q <= PH_CHARGE;
      end else begin
         unique case (phase_q)
            PH_CHARGE: begin
               // comparator ignored while any blanking runs
               if (sense && !blank_active) begin
                  phase_q <= PH_SLOW;
               end
            end
            PH_SLOW: begin
               if (cnt_q == CHOP_FAST_AT) begin
                  phase_q <= PH_FAST;
               end
            end
            PH_FAST: begin
               phase_q <= PH_FAST;
            end
            default: begin
               phase_q <= PH_CHARGE;
            end
         endcase
      end
   end

endmodule : hbd_chop

// ===== hw/hbd_ctrl.sv
// top of the dual h-bridge brushed dc motor control logic
// assumes host pins are synchronous to aclk and the strap is fixed in use
// registers reached over an axi4-lite slave with 4 bit byte address
//
// Functional notes
// - drive on: dir1 gives cw, dir2 ccw
// - drive on, both dirs low: outputs off
// - brake when drive low with a dir high, or both dirs
// - channel b decodes identically and independently
// - standby only when all six inputs low, or channel a's three when paralleled
// - digital blanking 4 or 6 clocks
// - comparator ignored during blanking
// - fixed 400 ns analog blanking too
// - blanking starts every charge period
// - blanking starts on any direction change
// - strap low two bridges, high paralleled
// - two-bridge mode: bridges run separately; a direction change on either still restarts blanking on both
// - paralleled: both halves follow channel a
// - paralleled: channel b inputs ignored
// - blanking select works in both modes
// - direct pwm and internal chopping both supported
// - cycle starts charge, slow at threshold; 20-clock analog window restarts every 16, masking sense after cycle one
// - fast decay from eleventh clock edge
// - sixteenth clock ends cycle, recharge
module hbd_ctrl
   import hbd_pkg::*;
(
   input  wire logic       aclk,                  // oscillator / system clock
   input  wire logic       aresetn,               // sync reset, active low
   // host logic pins
   input  wire logic       chan_a_dir_first,      // channel a direction 1
   input  wire logic       chan_a_dir_second,     // channel a direction 2
   input  wire logic       chan_a_drive_brake_in, // channel a drive/brake
   input  wire logic       chan_b_dir_first,      // channel b direction 1
   input  wire logic       chan_b_dir_second,     // channel b direction 2
   input  wire logic       chan_b_drive_brake_in, // channel b drive/brake
   input  wire logic       blank_length_select,   // 0: 4 clk, 1: 6 clk
   input  wire logic       bridge_parallel_strap, // 0: two bridges, 1: one
   input  wire logic       chan_a_current_sense,  // channel a threshold hit
   input  wire logic       chan_b_current_sense,  // channel b threshold hit
   // bridge outputs
   output hbd_pin_t        chan_a_out_plus,       // a+ level and enable
   output hbd_pin_t        chan_a_out_minus,      // a- level and enable
   output hbd_pin_t        chan_b_out_plus,       // b+ level and enable
   output hbd_pin_t        chan_b_out_minus,      // b- level and enable
   // axi4-lite slave
   input  wire logic [3:0] s_axi_awaddr,          // write address
   input  wire logic       s_axi_awvalid,         // write address valid
   output logic            s_axi_awready,         // write address ready
   input  wire logic [31:0] s_axi_wdata,          // write data
   input  wire logic [3:0] s_axi_wstrb,           // write byte enables
   input  wire logic       s_axi_wvalid,          // write data valid
   output logic            s_axi_wready,          // write data ready
   output logic [1:0]      s_axi_bresp,           // write response
   output logic            s_axi_bvalid,          // write response valid
   input  wire logic       s_axi_bready,          // write response ready
   input  wire logic [3:0] s_axi_araddr,          // read address
   input  wire logic       s_axi_arvalid,         // read address valid
   output logic            s_axi_arready,         // read address ready
   output logic [31:0]     s_axi_rdata,           // read data
   output logic [1:0]      s_axi_rresp,           // read response
   output logic            s_axi_rvalid,          // read data valid
   input  wire logic       s_axi_rready           // read data ready
);

   // ------------------------------------------------------------------
   // input capture
   // ------------------------------------------------------------------
   hbd_chan_in_t raw_q    [2];       // registered host inputs
   hbd_chan_in_t eff      [2];       // inputs after mode steering
   hbd_chan_in_t eff_prev_q [2];     // last cycle's steered inputs
   logic         blank_long_q;       // registered blanking select
   logic         parallel_q;         // registered strap
   logic [1:0]   sense_q;            // registered comparator results
   logic         chop_en_q;          // control register bit
   logic         all_low;            // device-wide standby condition
   logic         dir_change;         // any live direction toggled
   hbd_mode_t    mode   [2];         // decoded state per channel
   hbd_phase_t   phase  [2];         // decay phase per channel
   logic [1:0]   blank;              // blanking active per channel
   hbd_pin_t     plus_q [2];         // output register, plus side
   hbd_pin_t     minus_q[2];         // output register, minus side

   // pins are taken as synchronous; one register stage for timing only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         raw_q[0]     <= '0;
         raw_q[1]     <= '0;
         blank_long_q <= 1'b0;
         sense_q      <= 2'h0;
      end else begin
         raw_q[0]     <= '{chan_a_dir_first, chan_a_dir_second, chan_a_drive_brake_in};
         raw_q[1]     <= '{chan_b_dir_first, chan_b_dir_second, chan_b_drive_brake_in};
         blank_long_q <= blank_length_select;
         sense_q      <= {chan_b_current_sense, chan_a_current_sense};
      end
   end

   // strap sampled every clock; the host keeps it still in use
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         parallel_q <= 1'b0;
      end else begin
         parallel_q <= bridge_parallel_strap;
      end
   end

   // paralleled mode: half b copies channel a, b pins dropped
   assign eff[0] = raw_q[0];
   assign eff[1] = parallel_q ? raw_q[0] : raw_q[1];

   // standby: in paralleled mode the b pins count as low
   assign all_low = (raw_q[0] == '0) && (parallel_q || (raw_q[1] == '0));

   // history of the steered direction inputs for change detect
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eff_prev_q[0] <= '0;
         eff_prev_q[1] <= '0;
      end else begin
         eff_prev_q[0] <= eff[0];
         eff_prev_q[1] <= eff[1];
      end
   end

   // a toggle on either channel restarts blanking on both halves
   assign dir_change =
      (eff[0].dir_first  != eff_prev_q[0].dir_first)  ||
      (eff[0].dir_second != eff_prev_q[0].dir_second) ||
      (eff[1].dir_first  != eff_prev_q[1].dir_first)  ||
      (eff[1].dir_second != eff_prev_q[1].dir_second);

   // ------------------------------------------------------------------
   // per channel decode, chopping and output drive
   // ------------------------------------------------------------------
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic sense_eff;               // comparator seen by this half
      logic driving;                 // bridge carries motor current

      // paralleled halves share sense so both stay in lockstep
      assign sense_eff = parallel_q ? sense_q[0] : sense_q[ch];
      assign driving   = (mode[ch] == MODE_CW) || (mode[ch] == MODE_CCW);

      hbd_decode u_decode (
         .in_c    (eff[ch]),
         .all_low (all_low),
         .mode    (mode[ch])
      );

      hbd_chop u_chop (
         .aclk         (aclk),
         .aresetn      (aresetn),
         .chop_en      (chop_en_q),
         .driving      (driving),
         .blank_long   (blank_long_q),
         .dir_change   (dir_change),
         .sense        (sense_eff),
         .phase        (phase[ch]),
         .blank_active (blank[ch])
      );

      // output stage: state and decay phase to pin levels
      // fast decay reverses the bridge; slow decay shorts it low
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            plus_q[ch]  <= '{1'b0, 1'b1};
            minus_q[ch] <= '{1'b0, 1'b1};
         end else begin
            unique case (mode[ch])
               MODE_STANDBY, MODE_STOP: begin
                  plus_q[ch]  <= '{1'b0, 1'b1};
                  minus_q[ch] <= '{1'b0, 1'b1};
               end
               MODE_BRAKE: begin
                  plus_q[ch]  <= '{1'b0, 1'b0};
                  minus_q[ch] <= '{1'b0, 1'b0};
               end
               MODE_CW: begin
                  plus_q[ch]  <= '{phase[ch] == PH_CHARGE, 1'b0};
                  minus_q[ch] <= '{phase[ch] == PH_FAST,   1'b0};
               end
               MODE_CCW: begin
                  plus_q[ch]  <= '{phase[ch] == PH_FAST,   1'b0};
                  minus_q[ch] <= '{phase[ch] == PH_CHARGE, 1'b0};
               end
               default: begin
                  plus_q[ch]  <= '{1'b0, 1'b1};
                  minus_q[ch] <= '{1'b0, 1'b1};
               end
            endcase
         end
      end
   end

   assign chan_a_out_plus  = plus_q[0];
   assign chan_a_out_minus = minus_q[0];
   assign chan_b_out_plus  = plus_q[1];
   assign chan_b_out_minus = minus_q[1];

   // ------------------------------------------------------------------
   // axi4-lite slave: one write and one read in flight
   // ------------------------------------------------------------------
   logic        aw_full_q;           // write address held
   logic        w_full_q;            // write data held
   logic [3:0]  aw_addr_q;           // held write address
   logic [31:0] w_data_q;            // held write data
   logic [3:0]  w_strb_q;            // held byte enables
   logic        awready_q;           // address channel open
   logic        wready_q;            // data channel open
   logic        bvalid_q;            // response pending
   logic [1:0]  bresp_q;             // response code
   logic        arready_q;           // read address open
   logic        rvalid_q;            // read data pending
   logic [31:0] rdata_q;             // read data register
   logic [1:0]  rresp_q;             // read response code
   logic        do_write;            // both halves present
   logic [31:0] status_word;         // live status snapshot

   assign do_write = aw_full_q && w_full_q && !bvalid_q;

   // write address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q  <= 32'h0;
         w_strb_q  <= 4'h0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid && wready_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            wready_q <= 1'b0;
         end
         if (do_write) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            // status is read only; writes to it are accepted and dropped
            bresp_q   <= (aw_addr_q == REG_CTRL_OFS || aw_addr_q == REG_STATUS_OFS)
                         ? RESP_OKAY : RESP_SLVERR;
         end
         // reopen only after the response, so one write at a time
         if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // control register: chopping enable steers the decay logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chop_en_q <= CTRL_CHOP_EN_RST;
      end else if (do_write && aw_addr_q == REG_CTRL_OFS && w_strb_q[0]) begin
         chop_en_q <= w_data_q[CTRL_CHOP_EN_BIT];
      end
   end

   // status snapshot of the bridge's own state
   always_comb begin
      status_word = 32'h0;
      status_word[ST_MODE_A_LSB +: 3]  = mode[0];
      status_word[ST_MODE_B_LSB +: 3]  = mode[1];
      status_word[ST_PHASE_A_LSB +: 2] = phase[0];
      status_word[ST_PHASE_B_LSB +: 2] = phase[1];
      status_word[ST_BLANK_A_BIT]      = blank[0];
      status_word[ST_BLANK_B_BIT]      = blank[1];
      status_word[ST_PARALLEL_BIT]     = parallel_q;
   end

   // read channel: data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         unique case (s_axi_araddr)
            REG_CTRL_OFS: begin
               rdata_q <= {31'h0, chop_en_q};
               rresp_q <= RESP_OKAY;
            end
            REG_STATUS_OFS: begin
               rdata_q <= status_word;
               rresp_q <= RESP_OKAY;
            end
            default: begin
               // unmapped: zero data with a slave error
               rdata_q <= 32'h0;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

endmodule : hbd_ctrl

// ===== verif/hbd_props.sv
// checker: pin decode and reset levels at the hbd_ctrl ports
// assumes sense is masked and the strap only moves in reset
module hbd_props
   import hbd_pkg::*;
(
   input wire logic aclk,                  // clock
   input wire logic aresetn,               // reset, active low
   input wire logic chan_a_dir_first,      // a dir 1
   input wire logic chan_a_dir_second,     // a dir 2
   input wire logic chan_a_drive_brake_in, // a drive/brake
   input wire logic chan_b_dir_first,      // b dir 1
   input wire logic chan_b_dir_second,     // b dir 2
   input wire logic chan_b_drive_brake_in, // b drive/brake
   input wire logic bridge_parallel_strap, // mode strap
   input hbd_pin_t  chan_a_out_plus,       // a+
   input hbd_pin_t  chan_a_out_minus,      // a-
   input hbd_pin_t  chan_b_out_plus,       // b+
   input hbd_pin_t  chan_b_out_minus       // b-
);
   // outputs packed as {p.drv, p.oe_n, m.drv, m.oe_n}
   wire logic [3:0] ao = {chan_a_out_plus, chan_a_out_minus};
   wire logic [3:0] bo = {chan_b_out_plus, chan_b_out_minus};
   wire logic       st = bridge_parallel_strap; // paralleled when high
   logic [5:0] p1_q, p2_q;  // pins one and two edges back
   logic [2:0] rv_q;        // reset history, avoids stale pins at release
   wire logic       ok = (rv_q == 3'h7);
   // outputs answer two edges after the pins, so compare with p2_q
   always_ff @(posedge aclk) begin
      p1_q <= {chan_a_dir_first, chan_a_dir_second, chan_a_drive_brake_in,
               chan_b_dir_first, chan_b_dir_second, chan_b_drive_brake_in};
      p2_q <= p1_q;
      rv_q <= {rv_q[1:0], aresetn};
   end
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   reset_hiz_a: assert property (disable iff (1'b0) !aresetn |=> ao[2] && ao[0] && bo[2] && bo[0])
      else $error("outputs driven in reset");
   cw_drive_a: assert property (ok && p2_q[5:3] == 3'h5 |-> ao == 4'h8)
      else $error("cw decode wrong");
   ccw_drive_a: assert property (ok && p2_q[5:3] == 3'h3 |-> ao == 4'h2)
      else $error("ccw decode wrong");
   stop_hiz_a: assert property (ok && p2_q[5:3] == 3'h1 |-> ao[2] && ao[0])
      else $error("stop not hi-z");
   brake_low_a: assert property (ok && p2_q[5:3] inside {3'h2, 3'h4, 3'h6, 3'h7} |-> ao == 4'h0)
      else $error("brake not low");
   b_brake_a: assert property (ok && !st && p2_q[2:0] inside {3'h2, 3'h4, 3'h6, 3'h7} |-> bo == 4'h0)
      else $error("b brake wrong");
   standby_hiz_a: assert property (ok && p2_q == 6'h0 |-> ao[2] && ao[0] && bo[2] && bo[0])
      else $error("standby not hi-z");
   merge_follow_a: assert property (ok && st |-> bo == ao)
      else $error("halves differ");
endmodule : hbd_props

bind hbd_ctrl hbd_props u_hbd_props (.*);

// ===== verif/hbd_host.sv
// host pin model: drives the channel pins and the mode strap
// assumes requests come from the bench at aclk rising edges
module hbd_host (
   input  wire logic       aclk,                         // clock
   input  wire logic       aresetn,                      // reset, active low
   input  wire logic [5:0] pins_req,                     // a1 a2 pwm b1 b2 pwm
   input  wire logic       strap_req,                    // wanted bridge mode
   output logic            chan_a_dir_first = 1'b0,      // a dir 1
   output logic            chan_a_dir_second = 1'b0,     // a dir 2
   output logic            chan_a_drive_brake_in = 1'b0, // a drive/brake
   output logic            chan_b_dir_first = 1'b0,      // b dir 1
   output logic            chan_b_dir_second = 1'b0,     // b dir 2
   output logic            chan_b_drive_brake_in = 1'b0, // b drive/brake
   output logic            bridge_parallel_strap = 1'b0  // mode strap
);
   // all six pins move together one edge after the request
   always @(posedge aclk) begin
      {chan_a_dir_first, chan_a_dir_second, chan_a_drive_brake_in, chan_b_dir_first,
       chan_b_dir_second, chan_b_drive_brake_in} <= pins_req;
   end
   // strap moves only in reset, never while the bridge runs
   always @(posedge aclk) begin
      if (!aresetn) bridge_parallel_strap <= strap_req;
   end
endmodule : hbd_host

// ===== verif/tb_hbd_ctrl.sv
// testbench for hbd_ctrl: exhaustive and random pin decode, axi access
// assumes hbd_host drives the pins; sense comparators masked
module tb_hbd_ctrl
   import hbd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0, aresetn = 1'b0, strap_req = 1'b0, blank_length_select = 1'b0;
   logic chan_a_current_sense = 1'b0, chan_b_current_sense = 1'b0; // comparators, start low, randomized by each pins call
   logic [5:0] pins_req = 6'h0;  // requested pins
   logic chan_a_dir_first, chan_a_dir_second, chan_a_drive_brake_in, bridge_parallel_strap;
   logic chan_b_dir_first, chan_b_dir_second, chan_b_drive_brake_in;
   hbd_pin_t chan_a_out_plus, chan_a_out_minus, chan_b_out_plus, chan_b_out_minus;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int num_errors = 0, num_checks = 0, cyc = 0;
   hbd_ctrl u_hbd_ctrl (.*);
   hbd_host u_hbd_host (.*);
   initial begin
      forever #10 aclk = ~aclk;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // watchdog: a hang counts as a mismatch
   always @(posedge aclk) begin
      cyc++;
      if (cyc > 6000) begin
         num_errors++;
         final_report();
      end
   end
   task automatic check(string nm, logic [31:0] s, logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask : check
   // expected {p.drv, p.oe_n, m.drv, m.oe_n} from {dir1, dir2, drive}
   function automatic logic [3:0] dec(logic [2:0] p);
      case (p)
         3'h5: dec = 4'h8;          // cw
         3'h3: dec = 4'h2;          // ccw
         3'h1, 3'h0: dec = 4'h5;    // stop or standby, hi-z
         default: dec = 4'h0;       // short brake
      endcase
   endfunction : dec
   // drive level only matters while enabled
   function automatic logic [3:0] vis(hbd_pin_t p, hbd_pin_t m);
      vis = {p.drv & ~p.oe_n, p.oe_n, m.drv & ~m.oe_n, m.oe_n};
   endfunction : vis
   task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] e);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check("bresp", s_axi_bresp, e);
   endtask : wr
   task automatic rd(logic [3:0] a, logic [31:0] d, logic [1:0] e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      check("rdata", s_axi_rdata, d);
      check("rresp", s_axi_rresp, e);
   endtask : rd
   // host latch, input register, output register: read after the fourth edge
   task automatic pins(logic [5:0] p);
      logic [3:0] ea;
      @(posedge aclk);
      pins_req <= p;
      {chan_a_current_sense, chan_b_current_sense} <= 2'($urandom);
      repeat (4) @(posedge aclk);
      ea = dec(p[5:3]);
      check("chan a", vis(chan_a_out_plus, chan_a_out_minus), ea);
      check("chan b", vis(chan_b_out_plus, chan_b_out_minus), strap_req ? ea : dec(p[2:0]));
   endtask : pins
   // one strap setting: reset, all 64 pin codes, then random codes
   task automatic phase(logic s);
      @(posedge aclk);
      aresetn <= 1'b0;
      strap_req <= s;
      blank_length_select <= 1'($urandom);
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(4'h0, 32'h1, RESP_OKAY);
      for (int i = 0; i < 64; i++) pins(6'(i));
      repeat (64) pins(6'($urandom) & {3'h7, {3{!s}}});
      $display("test pin decode strap %0d done", s);
   endtask : phase
   initial begin
      void'($urandom(32'ha374b4ac));
      phase(1'b0);
      wr(4'h0, 32'h0, RESP_OKAY);
      rd(4'h0, 32'h0, RESP_OKAY);
      wr(4'h8, 32'h1, RESP_SLVERR);
      rd(4'hc, 32'h0, RESP_SLVERR);
      $display("test register access done");
      phase(1'b1);
      final_report();
   end
endmodule : tb_hbd_ctrl
